// ===== design/obc_regs.sv
/*
  Output bias configuration register bank with headset short-circuit
  debounce, bias current, driver mode, mic bias and input tie settings.
  Assumes a synchronous byte-wide register port from the control
  interface and synchronous detection inputs.
*/
// Operation
// - Debounce code sits in bits 7..5 of the driver control, reset 0.
// - Codes 0..7 give 0, 8, 16, 32, 64, 128, 256 and 512 us at 1 MHz.
// - The debounce sample period is one eighth of the debounce time.
// - The 1 MHz timer is master clock over a 7-bit divider when timer bit 7 is 1, else the oscillator; 0 = 128.
// - Bias current field: 00 default, 01 more, 11 most, 10 reserved.
// - Left driver is headphone when its bit is 0 and lineout when 1.
// - Right driver is headphone when its bit is 0 and lineout when 1.
// - Top mic bias bit set enables software power-down of the device.
// - Gate bit 0 holds mic bias off with detection on and no headset.
// - Mic bias level: 00 off, 01 2 V, 10 2.5 V, 11 analog rail.
// - Input one ties to common mode when its bit is 1 and unbypassed.
// - Input two ties to common mode when its bit is 1 and unbypassed.
`timescale 1ns/1ps
module obc_regs #(
  parameter int DIV_WIDTH = 7
) (
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic sw_reset, // Software reset pulse
  input wire logic mclk_en, // Master clock enable pulse
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data
  input wire logic short_raw, // Raw headset short detect
  input wire logic headset_det_en, // Headset detection enabled
  input wire logic headset_in, // Headset inserted
  input wire logic in1_bypass, // Input one used for bypass
  input wire logic in2_bypass, // Input two used for bypass
  output logic short_det, // Debounced short detect
  output logic [1:0] dac_bias_mode, // Bias current mode
  output logic left_output_driver_lineout, // Left driver lineout
  output logic right_output_driver_lineout, // Right driver lineout
  output logic sw_power_down, // Software power-down enable
  output logic microphone_bias_on, // Mic bias powered
  output logic [1:0] microphone_bias_output_level, // Mic bias level
  output logic analog_input_one_to_cm, // Input one tied to common mode
  output logic analog_input_two_to_cm // Input two tied to common mode
);
  typedef enum logic [2:0] {
    DB_IDLE = 3'h1,
    DB_COUNT = 3'h2,
    DB_HELD = 3'h4
  } obc_db_state_t;

  logic [7:0] headphone_driver_control;
  logic [7:0] mic_bias_and_power_down;
  logic [7:0] input_common_mode_settings;
  logic [7:0] timer_clock_divider;
  logic [4:0] osc_count;
  logic osc_en;
  logic timer_src_en;
  logic timer_tick;
  logic mclk_tick;
  logic [6:0] pre_count;
  logic sample_tick;
  logic [2:0] deb_code;
  logic [3:0] deb_count;
  obc_db_state_t db_state;
  logic [6:0] next_pre_limit;
  logic [7:0] next_rdata;
  logic wr_any;

  assign wr_any = reg_wr && !sw_reset;
  assign deb_code = headphone_driver_control[obc_pkg::HP_DEB_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are forced to zero on store

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      headphone_driver_control <= obc_pkg::HP_RESET;
      mic_bias_and_power_down <= obc_pkg::MB_RESET;
      input_common_mode_settings <= obc_pkg::CM_RESET;
      timer_clock_divider <= obc_pkg::TD_RESET;
    end else if (sw_reset) begin
      headphone_driver_control <= obc_pkg::HP_RESET;
      mic_bias_and_power_down <= obc_pkg::MB_RESET;
      input_common_mode_settings <= obc_pkg::CM_RESET;
      timer_clock_divider <= obc_pkg::TD_RESET;
    end else if (wr_any) begin
      case (reg_addr)
        obc_pkg::ADDR_HP_DRIVER: begin
          headphone_driver_control <= reg_wdata & obc_pkg::HP_WRITE_MASK;
        end
        obc_pkg::ADDR_MIC_BIAS: begin
          mic_bias_and_power_down <= reg_wdata & obc_pkg::MB_WRITE_MASK;
        end
        obc_pkg::ADDR_INPUT_CM: begin
          input_common_mode_settings <= reg_wdata & obc_pkg::CM_WRITE_MASK;
        end
        obc_pkg::ADDR_TIMER_DIV: begin
          timer_clock_divider <= reg_wdata;
        end
        default: begin
          // Gap register is not stored; software keeps off it
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read back

  always_comb begin
    case (reg_addr)
      obc_pkg::ADDR_HP_DRIVER: next_rdata = headphone_driver_control;
      obc_pkg::ADDR_MIC_BIAS: next_rdata = mic_bias_and_power_down;
      obc_pkg::ADDR_INPUT_CM: next_rdata = input_common_mode_settings;
      obc_pkg::ADDR_TIMER_DIV: next_rdata = timer_clock_divider;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 1 MHz timer source: internal oscillator stand-in or divided master

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      osc_count <= 5'h00;
      osc_en <= 1'b0;
    end else if (osc_count == 5'(obc_pkg::OSC_DIV - 1)) begin
      osc_count <= 5'h00;
      osc_en <= 1'b1;
    end else begin
      osc_count <= osc_count + 5'h01;
      osc_en <= 1'b0;
    end
  end

  always_comb begin
    if (timer_clock_divider[obc_pkg::TD_SEL_BIT]) begin
      timer_src_en = mclk_en;
      timer_tick = mclk_tick;
    end else begin
      // Oscillator already runs at 1 MHz, so it skips the divider
      timer_src_en = 1'b0;
      timer_tick = osc_en;
    end
  end

  obc_tick_div #(
    .WIDTH(DIV_WIDTH)
  ) u_timer_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .en_in(timer_src_en),
    .div(timer_clock_divider[DIV_WIDTH-1:0]),
    .tick(mclk_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sample clock at one eighth of the debounce time

  always_comb begin
    case (deb_code)
      3'h1: next_pre_limit = 7'h01;
      3'h2: next_pre_limit = 7'h02;
      3'h3: next_pre_limit = 7'h04;
      3'h4: next_pre_limit = 7'h08;
      3'h5: next_pre_limit = 7'h10;
      3'h6: next_pre_limit = 7'h20;
      3'h7: next_pre_limit = 7'h40;
      default: next_pre_limit = 7'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_count <= 7'h00;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (timer_tick) begin
        if (pre_count >= next_pre_limit - 7'h01) begin
          pre_count <= 7'h00;
          sample_tick <= 1'b1;
        end else begin
          pre_count <= pre_count + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Debounce: short must hold for eight samples; code zero passes direct

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      db_state <= DB_IDLE;
      deb_count <= 4'h0;
      short_det <= 1'b0;
    end else if (deb_code == 3'h0) begin
      db_state <= short_raw ? DB_HELD : DB_IDLE;
      deb_count <= 4'h0;
      short_det <= short_raw;
    end else if (!short_raw) begin
      db_state <= DB_IDLE;
      deb_count <= 4'h0;
      short_det <= 1'b0;
    end else begin
      case (db_state)
        DB_IDLE: begin
          db_state <= DB_COUNT;
          deb_count <= 4'h0;
        end
        DB_COUNT: begin
          if (sample_tick) begin
            if (deb_count == 4'(obc_pkg::DEB_SAMPLES - 1)) begin
              db_state <= DB_HELD;
              short_det <= 1'b1;
            end else begin
              deb_count <= deb_count + 4'h1;
            end
          end
        end
        DB_HELD: begin
          short_det <= 1'b1;
        end
        default: begin
          db_state <= DB_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control outputs, all registered

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dac_bias_mode <= 2'h0;
      left_output_driver_lineout <= 1'b0;
      right_output_driver_lineout <= 1'b0;
    end else begin
      // Reserved code keeps the last legal mode rather than guess
      if (headphone_driver_control[obc_pkg::HP_PERF_LSB +: 2] !=
          obc_pkg::PERF_RESERVED) begin
        dac_bias_mode <= headphone_driver_control[obc_pkg::HP_PERF_LSB +: 2];
      end
      left_output_driver_lineout <=
        headphone_driver_control[obc_pkg::HP_LEFT_BIT];
      right_output_driver_lineout <=
        headphone_driver_control[obc_pkg::HP_RIGHT_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sw_power_down <= 1'b0;
      microphone_bias_on <= 1'b0;
      microphone_bias_output_level <= 2'h0;
    end else begin
      sw_power_down <= mic_bias_and_power_down[obc_pkg::MB_PDN_BIT];
      microphone_bias_output_level <=
        mic_bias_and_power_down[obc_pkg::MB_LEVEL_LSB +: 2];
      microphone_bias_on <=
        (mic_bias_and_power_down[obc_pkg::MB_LEVEL_LSB +: 2] != 2'h0) &&
        (mic_bias_and_power_down[obc_pkg::MB_GATE_BIT] ||
         !headset_det_en || headset_in);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      analog_input_one_to_cm <= 1'b0;
      analog_input_two_to_cm <= 1'b0;
    end else begin
      analog_input_one_to_cm <= !in1_bypass &&
        input_common_mode_settings[obc_pkg::CM_IN1_BIT];
      analog_input_two_to_cm <= !in2_bypass &&
        input_common_mode_settings[obc_pkg::CM_IN2_BIT];
    end
  end
endmodule : obc_regs

// ===== common/obc_pkg.sv
/*
  Constants for the output bias configuration register bank: register
  offsets, field positions, reset values and timer figures.
  Assumes a 20 MHz system clock and byte-wide register access.
*/
package obc_pkg;
  localparam logic [7:0] ADDR_HP_DRIVER = 8'h2C;
  localparam logic [7:0] ADDR_RSVD_GAP = 8'h2D;
  localparam logic [7:0] ADDR_MIC_BIAS = 8'h2E;
  localparam logic [7:0] ADDR_INPUT_CM = 8'h32;
  localparam logic [7:0] ADDR_TIMER_DIV = 8'h90;

  localparam int HP_DEB_LSB = 5;
  localparam int HP_PERF_LSB = 3;
  localparam int HP_LEFT_BIT = 2;
  localparam int HP_RIGHT_BIT = 1;
  localparam int MB_PDN_BIT = 7;
  localparam int MB_GATE_BIT = 3;
  localparam int MB_LEVEL_LSB = 0;
  localparam int CM_IN1_BIT = 7;
  localparam int CM_IN2_BIT = 6;
  localparam int TD_SEL_BIT = 7;

  localparam logic [7:0] HP_WRITE_MASK = 8'hFE;
  localparam logic [7:0] MB_WRITE_MASK = 8'h8B;
  localparam logic [7:0] CM_WRITE_MASK = 8'hC0;

  localparam logic [7:0] HP_RESET = 8'h00;
  localparam logic [7:0] MB_RESET = 8'h00;
  localparam logic [7:0] CM_RESET = 8'h00;
  localparam logic [7:0] TD_RESET = 8'h81;

  localparam logic [1:0] PERF_RESERVED = 2'h2;

  localparam int CLK_HZ = 20000000;
  localparam int TIMER_HZ = 1000000;
  localparam int OSC_DIV = CLK_HZ / TIMER_HZ;
  localparam int DEB_SAMPLES = 8;
endpackage : obc_pkg

// ===== design/obc_tick_div.sv
/*
  Programmable divider giving a one-cycle enable pulse every N input
  enables. Code zero divides by 2**WIDTH.
  Assumes one clock and a synchronous enable input.
*/
`timescale 1ns/1ps
module obc_tick_div #(
  parameter int WIDTH = 7
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic en_in, // Input rate enable
  input wire logic [WIDTH-1:0] div, // Divide code, zero is 2**WIDTH
  output logic tick // One pulse per N enables
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (en_in) begin
        if (count == div - WIDTH'(1)) begin
          count <= '0;
          tick <= 1'b1;
        end else begin
          count <= count + WIDTH'(1);
        end
      end
    end
  end
endmodule : obc_tick_div

// ===== bench/obc_regs_properties.sv
/*
  Port checker for the output bias configuration register bank.
  Bound to obc_regs from the bench top file; sees ports only.
*/
`timescale 1ns/1ps
module obc_regs_properties #(
  parameter int DIV_WIDTH = 7
) (
  input wire logic clk_sys, // Clock
  input wire logic reset_n, // Reset
  input wire logic sw_reset, // Soft reset
  input wire logic mclk_en, // Timer enable
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Data in
  input wire logic [7:0] reg_rdata, // Data out
  input wire logic short_raw, // Raw short
  input wire logic headset_det_en, // Detect on
  input wire logic headset_in, // Inserted
  input wire logic in1_bypass, // Bypass one
  input wire logic in2_bypass, // Bypass two
  input wire logic short_det, // Short
  input wire logic [1:0] dac_bias_mode, // Bias mode
  input wire logic left_output_driver_lineout, // Left mode
  input wire logic right_output_driver_lineout, // Right mode
  input wire logic sw_power_down, // Power-down
  input wire logic microphone_bias_on, // Bias on
  input wire logic [1:0] microphone_bias_output_level, // Level
  input wire logic analog_input_one_to_cm, // Tie one
  input wire logic analog_input_two_to_cm // Tie two
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////
  sequence wr_hp;
    reg_wr && !sw_reset && reg_addr == obc_pkg::ADDR_HP_DRIVER;
  endsequence
  sequence wr_mb;
    reg_wr && !sw_reset && reg_addr == obc_pkg::ADDR_MIC_BIAS;
  endsequence
  ////////////////////////////////////////////////////////////////////
  left_mode_a: assert property (
    wr_hp |=> ##1 left_output_driver_lineout == $past(reg_wdata[2], 2))
    else $error("left driver mode wrong");
  right_mode_a: assert property (
    wr_hp |=> ##1 right_output_driver_lineout == $past(reg_wdata[1], 2))
    else $error("right driver mode wrong");
  bias_mode_a: assert property (
    wr_hp ##0 reg_wdata[4:3] != obc_pkg::PERF_RESERVED
    |=> ##1 dac_bias_mode == $past(reg_wdata[4:3], 2))
    else $error("bias mode wrong");
  no_rsvd_mode_a: assert property (
    dac_bias_mode != obc_pkg::PERF_RESERVED)
    else $error("reserved bias mode shown");
  power_down_a: assert property (
    wr_mb |=> ##1 sw_power_down == $past(reg_wdata[7], 2))
    else $error("power-down wrong");
  bias_level_a: assert property (
    wr_mb |=> ##1 microphone_bias_output_level == $past(reg_wdata[1:0], 2))
    else $error("mic bias level wrong");
  bias_off_a: assert property (
    microphone_bias_on |-> microphone_bias_output_level != 2'h0)
    else $error("mic bias on at level zero");
  tie_one_a: assert property (
    reg_wr && !sw_reset && reg_addr == obc_pkg::ADDR_INPUT_CM
    ##0 !in1_bypass [*3] |-> analog_input_one_to_cm == $past(reg_wdata[7], 2))
    else $error("input one tie wrong");
  gap_read_a: assert property (
    reg_rd && reg_addr == obc_pkg::ADDR_RSVD_GAP |=> reg_rdata == 8'h00)
    else $error("gap register reads nonzero");
  short_drop_a: assert property (
    short_det |-> $past(short_raw))
    else $error("short seen without raw short");
  reset_out_a: assert property (
    $rose(reset_n) |-> !sw_power_down && dac_bias_mode == 2'h0)
    else $error("outputs not reset");
  cover property (wr_hp);
  cover property (short_det);
  cover property (microphone_bias_on);
endmodule : obc_regs_properties

// ===== bench/obc_regs_tb.sv
/*
  Self-checking bench for obc_regs: reset values, driver modes,
  mic bias, input ties, debounce and soft reset.
  Assumes the checker file compiled alongside.
*/
`timescale 1ns/1ps
module obc_regs_tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, sw_reset = 1'b0, mclk_en = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, short_raw = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic headset_det_en = 1'b0, headset_in = 1'b0;
  logic in1_bypass = 1'b0, in2_bypass = 1'b0;
  logic short_det, sw_power_down, microphone_bias_on;
  logic [1:0] dac_bias_mode, microphone_bias_output_level;
  logic left_output_driver_lineout, right_output_driver_lineout;
  logic analog_input_one_to_cm, analog_input_two_to_cm;
  int err_count = 0;
  int cmp_count = 0;
  int div = 0;
  obc_regs uut (.*);
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // One master tick per 20 cycles gives 1 MHz at divide code 1
  always @(posedge clk_sys) begin
    div <= (div == 19) ? 0 : div + 1;
    mclk_en <= (div == 19);
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(sw_power_down, 0);
    chk({left_output_driver_lineout, right_output_driver_lineout}, 0);
    rd(8'h2C, 8'h00);
    rd(8'h2E, 8'h00);
    rd(8'h32, 8'h00);
    rd(8'h90, 8'h81);
    $display("test reset done");
  endtask : t_reset
  task automatic t_driver;
    logic [1:0] m;
    logic [1:0] c;
    m = 2'h0;
    wr(8'h2C, 8'hFE);
    rd(8'h2C, 8'hFE);
    // Gray order puts the reserved code after code 3
    for (int i = 0; i < 4; i++) begin
      c = 2'(i ^ (i >> 1));
      if (c != 2'h2) m = c;
      wr(8'h2C, {3'h0, c, i[0], i[1], 1'b0});
      cyc(2);
      chk(dac_bias_mode, m);
      chk(left_output_driver_lineout, i[0]);
      chk(right_output_driver_lineout, i[1]);
    end
    $display("test driver done");
  endtask : t_driver
  task automatic t_mic;
    wr(8'h2E, 8'h8B);
    rd(8'h2E, 8'h8B);
    chk(sw_power_down, 1);
    // Gap register is read only; software never writes it
    rd(8'h2D, 8'h00);
    rd(8'h2E, 8'h8B);
    rd(8'h40, 8'h00);
    @(posedge clk_sys);
    headset_det_en <= 1'b1;
    wr(8'h2E, 8'h01);
    cyc(3);
    chk(microphone_bias_on, 0);
    chk(sw_power_down, 0);
    @(posedge clk_sys);
    headset_in <= 1'b1;
    cyc(3);
    chk(microphone_bias_on, 1);
    @(posedge clk_sys);
    headset_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h2E, 8'h08 | 8'(i));
      cyc(3);
      chk(microphone_bias_output_level, i);
      chk(microphone_bias_on, i != 0);
    end
    $display("test mic bias done");
  endtask : t_mic
  task automatic t_cm;
    wr(8'h32, 8'hC0);
    rd(8'h32, 8'hC0);
    chk({analog_input_one_to_cm, analog_input_two_to_cm}, 3);
    wr(8'h32, 8'h40);
    cyc(2);
    chk({analog_input_one_to_cm, analog_input_two_to_cm}, 1);
    @(posedge clk_sys);
    in2_bypass <= 1'b1;
    cyc(3);
    chk(analog_input_two_to_cm, 0);
    $display("test input tie done");
  endtask : t_cm
  task automatic deb(input logic [2:0] code, input int lo, input int hi);
    int n;
    wr(8'h2C, {code, 5'h00});
    cyc(2);
    @(posedge clk_sys);
    short_raw <= 1'b1;
    cyc(lo);
    chk(short_det, 0);
    n = lo;
    while (short_det !== 1'b1 && n < hi) begin
      cyc(1);
      n++;
    end
    chk(short_det, 1);
    @(posedge clk_sys);
    short_raw <= 1'b0;
    cyc(2);
    chk(short_det, 0);
  endtask : deb
  task automatic t_deb;
    deb(3'h0, 0, 3);
    deb(3'h1, 130, 200);
    deb(3'h3, 500, 760);
    wr(8'h90, 8'h82);
    deb(3'h1, 270, 400);
    // Internal oscillator ignores the divide code
    wr(8'h90, 8'h02);
    deb(3'h1, 130, 200);
    $display("test debounce done");
  endtask : t_deb
  task automatic t_soft;
    wr(8'h2E, 8'h81);
    @(posedge clk_sys);
    sw_reset <= 1'b1;
    @(posedge clk_sys);
    sw_reset <= 1'b0;
    rd(8'h2E, 8'h00);
    rd(8'h90, 8'h81);
    cyc(1);
    chk(sw_power_down, 0);
    $display("test soft reset done");
  endtask : t_soft
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    cyc(1);
    t_reset();
    t_driver();
    t_mic();
    t_cm();
    t_deb();
    t_soft();
    results();
  end
  // Tests need about 1400 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    results();
  end
endmodule : obc_regs_tb
bind obc_regs obc_regs_properties #(.DIV_WIDTH(DIV_WIDTH)) u_props (.*);
